//--- hdl/adcmd_pkg.sv
/*
  Constants and types for the converter mode-pin decoder.
  Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package adcmd_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int RANGE_SETTLE_US = 80;
  // Settle is a typical figure, used as is; the product is a whole cycle count
  localparam int RANGE_SETTLE_CYC = RANGE_SETTLE_US * CLK_MHZ;
  localparam int RECOVER_CYC_DEF = 2500;
  localparam int CNT_W = 16;

  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_LSB = 4'h8;
  localparam logic [3:0] OFS_CODE = 4'hC;

  // CTRL fields
  localparam int CTRL_TRACK_BIT = 0;
  localparam logic CTRL_TRACK_RST = 1'b1;

  // STATUS fields
  localparam int ST_REF_INT = 0;
  localparam int ST_RANGE10 = 1;
  localparam int ST_PWR_LO = 2;
  localparam int ST_IF_LO = 4;
  localparam int ST_BUSY = 6;
  localparam int ST_REF_IO = 7;

  // ****************************************
  // Code format
  // ****************************************
  localparam int CODE_BITS = 18;
  localparam logic [31:0] CODE_STEPS = 32'h0004_0000;
  // Step size in picovolts: span / 262144
  localparam logic [31:0] LSB_PV_10V = 32'h048C_2B58;
  localparam logic [31:0] LSB_PV_5V = 32'h0246_15AC;
  localparam logic [31:0] CODE_INFO = 32'h0000_0012;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {
    ADCMD_PWR_NORMAL,
    ADCMD_PWR_STANDBY,
    ADCMD_PWR_SHUTDOWN
  } adcmd_pwr_t;

  typedef enum logic [1:0] {
    ADCMD_IF_PARALLEL,
    ADCMD_IF_BYTE,
    ADCMD_IF_SERIAL
  } adcmd_iface_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic track_en;
    logic range_q;
    logic pdn_q;
    logic [CNT_W-1:0] settle;
    logic busy;
  } adcmd_state_t;
endpackage

//--- hdl/adcmd_decoder.sv
/*
  Mode-pin decoder: reference, range, power state and readout interface
  follow the pins combinationally; an Avalon-MM slave exposes status,
  step size and a settle tracker.
  Assumes pin levels synchronous to clk_sys for the register view only.
*/
// Function
// - Reference select high enables and uses the internal band-gap.
// - Select low powers band-gap down; host must supply external reference.
// - In external mode the reference pin becomes a high-impedance input.
// - Internal reference buffer stays enabled whatever the select level.
// - Reference pin behaviour follows the select level with no clock.
// - At power-up the reference mode follows the select level.
// - Range high gives the 20 V (+/-10 V) span, low the 10 V (+/-5 V) span.
// - Range changes apply immediately, unsynchronised.
// - Power-down high is normal; low picks standby or shutdown by range.
// - Shutdown drops core and regulator power, buffer stays on; standby keeps reference and regulators.
// - Interface select low gives parallel word readout.
// - Interface select high: byte lane low serial, high parallel-byte.
// - Results are 18-bit two's complement for every span and channel.
// - One step is span over 262144.
`timescale 1ns/1ps
module adcmd_decoder #(
  parameter int RECOVER_CYC = adcmd_pkg::RECOVER_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mode pins
  input wire logic reference_select,
  input wire logic range_select,
  input wire logic power_down_n,
  input wire logic interface_select,
  input wire logic byte_lane_select,
  // Reference pin
  input wire logic reference_io_pin_in,
  output logic reference_io_pin_out,
  output logic reference_io_pin_oe,
  // Analog controls
  output logic bandgap_en,
  output logic ref_buffer_en,
  output logic ref_reg_pwr_en,
  output logic core_pwr_en,
  output logic range_10v,
  output adcmd_pkg::adcmd_pwr_t power_state,
  output adcmd_pkg::adcmd_iface_t iface_mode,
  output logic settle_busy,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  if (RECOVER_CYC < 1 || RECOVER_CYC >= (1 << adcmd_pkg::CNT_W))
  begin : g_bad_recover
    $error("RECOVER_CYC out of counter range");
  end
  if (adcmd_pkg::RANGE_SETTLE_CYC >= (1 << adcmd_pkg::CNT_W))
  begin : g_bad_settle
    $error("Settle count out of counter range");
  end

  // ****************************************
  // Pin decode, no clock involved
  // ****************************************
  // pure pin decode
  // Outputs here bypass flops on purpose: the pins act at once
  always_comb
  begin
    bandgap_en = reference_select;
    reference_io_pin_oe = reference_select;
    reference_io_pin_out = reference_select;
    ref_buffer_en = 1'b1;
    range_10v = range_select;
    if (power_down_n)
    begin
      power_state = adcmd_pkg::ADCMD_PWR_NORMAL;
    end
    else if (range_select)
    begin
      power_state = adcmd_pkg::ADCMD_PWR_STANDBY;
    end
    else
    begin
      power_state = adcmd_pkg::ADCMD_PWR_SHUTDOWN;
    end
    core_pwr_en = power_down_n;
    ref_reg_pwr_en = power_down_n | range_select;
    // serial or byte by lane select
    if (!interface_select)
    begin
      iface_mode = adcmd_pkg::ADCMD_IF_PARALLEL;
    end
    else if (byte_lane_select)
    begin
      iface_mode = adcmd_pkg::ADCMD_IF_BYTE;
    end
    else
    begin
      iface_mode = adcmd_pkg::ADCMD_IF_SERIAL;
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  adcmd_pkg::adcmd_state_t state_ff;
  adcmd_pkg::adcmd_state_t nxt_state;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic take;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[adcmd_pkg::ST_REF_INT] = reference_select;
    status_word[adcmd_pkg::ST_RANGE10] = range_select;
    status_word[adcmd_pkg::ST_PWR_LO +: 2] = power_state;
    status_word[adcmd_pkg::ST_IF_LO +: 2] = iface_mode;
    status_word[adcmd_pkg::ST_BUSY] = state_ff.busy;
    status_word[adcmd_pkg::ST_REF_IO] = reference_io_pin_in;
    rd_word = 32'h0000_0000;
    unique case (avs_address)
      adcmd_pkg::OFS_CTRL: rd_word[adcmd_pkg::CTRL_TRACK_BIT] = state_ff.track_en;
      adcmd_pkg::OFS_STATUS: rd_word = status_word;
      adcmd_pkg::OFS_LSB: rd_word = range_select ? adcmd_pkg::LSB_PV_10V
                                                 : adcmd_pkg::LSB_PV_5V;
      adcmd_pkg::OFS_CODE: rd_word = adcmd_pkg::CODE_INFO;
      default: rd_word = 32'h0000_0000;
    endcase
    // Request taken once; answer one cycle later
    take = (avs_read | avs_write) & state_ff.waitreq;

    nxt_state = state_ff;
    nxt_state.range_q = range_select;
    nxt_state.pdn_q = power_down_n;
    nxt_state.waitreq = ~take;
    if (take)
    begin
      nxt_state.rdata = avs_read ? rd_word : 32'h0000_0000;
    end
    if (avs_write && !state_ff.waitreq && avs_address == adcmd_pkg::OFS_CTRL)
    begin
      nxt_state.track_en = avs_writedata[adcmd_pkg::CTRL_TRACK_BIT];
    end
    // tracks host settle wait after power-down exit or range change
    if (state_ff.track_en && power_down_n && !state_ff.pdn_q)
    begin
      nxt_state.settle = adcmd_pkg::CNT_W'(RECOVER_CYC);
      nxt_state.busy = 1'b1;
    end
    else if (state_ff.track_en && range_select != state_ff.range_q)
    begin
      nxt_state.settle = adcmd_pkg::CNT_W'(adcmd_pkg::RANGE_SETTLE_CYC);
      nxt_state.busy = 1'b1;
    end
    else if (state_ff.settle > adcmd_pkg::CNT_W'(1))
    begin
      nxt_state.settle = state_ff.settle - adcmd_pkg::CNT_W'(1);
    end
    else
    begin
      nxt_state.settle = '0;
      nxt_state.busy = 1'b0;
    end
  end

  // mode is never latched, so power-up follows the pin
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // Edge detectors start at the pin levels, so no false settle after reset
      state_ff <= '{waitreq: 1'b1, rdata: 32'h0000_0000,
                    track_en: adcmd_pkg::CTRL_TRACK_RST, range_q: range_select,
                    pdn_q: power_down_n, settle: '0, busy: 1'b0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign avs_waitrequest = state_ff.waitreq;
  assign avs_readdata = state_ff.rdata;
  assign settle_busy = state_ff.busy;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Eight cycles prove the hold; the full count would slow the tools
  sequence s_busy_hold;
    settle_busy [*8];
  endsequence

  sequence s_bus_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  sequence s_read_take;
    avs_read && avs_waitrequest;
  endsequence

  sequence s_recover_start;
    state_ff.track_en && power_down_n && !state_ff.pdn_q;
  endsequence

  chk_ref_internal: assert property (
    reference_select |-> bandgap_en && reference_io_pin_oe)
    else $error("internal reference not enabled");

  chk_bandgap_off: assert property (
    !reference_select |-> !bandgap_en)
    else $error("band-gap still on in external mode");

  chk_ref_external: assert property (
    !reference_select |-> !reference_io_pin_oe)
    else $error("external mode still drives reference pin");

  chk_buffer_on: assert property (
    ref_buffer_en)
    else $error("reference buffer off");

  chk_ref_pin_level: assert property (
    reference_io_pin_out == reference_select)
    else $error("reference pin level does not follow select");

  chk_range_span: assert property (
    range_10v == range_select)
    else $error("span does not follow range pin");

  chk_power_pick: assert property (
    !power_down_n |-> power_state == (range_select ? adcmd_pkg::ADCMD_PWR_STANDBY
                                                   : adcmd_pkg::ADCMD_PWR_SHUTDOWN))
    else $error("low-power state pick wrong");

  chk_power_normal: assert property (
    power_down_n |-> core_pwr_en && ref_reg_pwr_en
                     && power_state == adcmd_pkg::ADCMD_PWR_NORMAL)
    else $error("normal power state wrong");

  chk_power_modes: assert property (
    !power_down_n |-> !core_pwr_en && (ref_reg_pwr_en == range_select))
    else $error("low-power state wrong");

  chk_iface_par: assert property (
    !interface_select |-> iface_mode == adcmd_pkg::ADCMD_IF_PARALLEL)
    else $error("parallel readout not selected");

  chk_iface_sel: assert property (
    interface_select |-> iface_mode == (byte_lane_select ? adcmd_pkg::ADCMD_IF_BYTE
                                                         : adcmd_pkg::ADCMD_IF_SERIAL))
    else $error("interface decode wrong");

  chk_settle_start: assert property (
    state_ff.track_en && power_down_n && state_ff.pdn_q && $changed(range_select)
    |=> s_busy_hold)
    else $error("settle busy not held after range change");

  chk_recover_load: assert property (
    s_recover_start |=> settle_busy && state_ff.settle == adcmd_pkg::CNT_W'(RECOVER_CYC))
    else $error("recovery count not loaded");

  chk_lsb_read: assert property (
    s_read_take ##0 avs_address == adcmd_pkg::OFS_LSB
    |=> (avs_readdata == ($past(range_select) ? adcmd_pkg::LSB_PV_10V
                                             : adcmd_pkg::LSB_PV_5V)) ##0 s_bus_answer)
    else $error("step size read wrong");

  chk_code_read: assert property (
    s_read_take ##0 avs_address == adcmd_pkg::OFS_CODE
    |=> (avs_readdata == 32'(adcmd_pkg::CODE_BITS)) ##0 s_bus_answer)
    else $error("code format read wrong");

  chk_track_write: assert property (
    avs_write && !avs_waitrequest && avs_address == adcmd_pkg::OFS_CTRL
    |=> state_ff.track_en == $past(avs_writedata[adcmd_pkg::CTRL_TRACK_BIT]))
    else $error("tracker switch write lost");
endmodule

//--- sim/adcmd_host.sv
/*
  Host-side model of the reference pin.
  Assumes the decoder drives the pin only while its enable is high.
*/
`timescale 1ns/1ps
module adcmd_host (
  // Reference pin
  input wire logic pin_out,
  input wire logic pin_oe,
  // Host reference level
  input wire logic ext_level,
  output logic pin_in
);
  assign pin_in = pin_oe ? pin_out : ext_level;
endmodule

//--- sim/tb.sv
/*
  Self-checking bench for the mode-pin decoder.
  Assumes the host model on the reference pin and a 25 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  logic clk_sys, rst_n, reference_select, range_select, power_down_n;
  logic interface_select, byte_lane_select, ext_level, pin_in, pin_out, pin_oe;
  logic bandgap_en, ref_buffer_en, ref_reg_pwr_en, core_pwr_en, range_10v;
  logic settle_busy, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  adcmd_pkg::adcmd_pwr_t power_state;
  adcmd_pkg::adcmd_iface_t iface_mode;
  int n_mismatch, cmp_count, n;
  // ****************************************
  // Instances
  // ****************************************
  adcmd_decoder #(.RECOVER_CYC(4)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reference_select(reference_select), .range_select(range_select),
    .power_down_n(power_down_n), .interface_select(interface_select),
    .byte_lane_select(byte_lane_select), .reference_io_pin_in(pin_in),
    .reference_io_pin_out(pin_out), .reference_io_pin_oe(pin_oe),
    .bandgap_en(bandgap_en), .ref_buffer_en(ref_buffer_en),
    .ref_reg_pwr_en(ref_reg_pwr_en), .core_pwr_en(core_pwr_en),
    .range_10v(range_10v), .power_state(power_state), .iface_mode(iface_mode),
    .settle_busy(settle_busy), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  adcmd_host u_host (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));
  // ****************************************
  // Shared tasks
  // ****************************************
  task tally_and_finish;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t word got %h exp %h", $time, g, e);
    end
  endtask
  // Held until waitrequest is seen low; bounded
  task bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !we;
    avs_write <= we;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  // Edges with settle_busy high, bounded
  task busy_len;
    int k;
    k = 0;
    n = 0;
    while (settle_busy !== 1'b1 && k < 10)
    begin
      @(posedge clk_sys);
      k++;
    end
    while (settle_busy === 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (k == 10 || n == 3000)
    begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Mid-cycle checks show no clock is involved
  task t_ref;
    // Host level differs from the low drive, so a stuck enable shows up
    ext_level <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      reference_select <= i[0];
      #5;
      chk_word(bandgap_en, i[0]);
      chk_word(pin_oe, i[0]);
      chk_word(ref_buffer_en, 1'b1);
      bus(1'b0, adcmd_pkg::OFS_STATUS, 32'h0000_0000);
      chk_word({d[7], d[0]}, {1'b1, i[0]});
    end
    $display("t_ref done");
  endtask
  task t_pwr;
    logic [1:0] ps;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      power_down_n <= i[1];
      range_select <= i[0];
      ps = i[1] ? 2'h0 : (i[0] ? 2'h1 : 2'h2);
      #5;
      chk_word(power_state, ps);
      chk_word({core_pwr_en, ref_reg_pwr_en}, {i[1], i[1] | i[0]});
      chk_word(range_10v, i[0]);
      bus(1'b0, adcmd_pkg::OFS_STATUS, 32'h0000_0000);
      chk_word(d[3:1], {ps, i[0]});
    end
    $display("t_pwr done");
  endtask
  task t_iface;
    logic [1:0] im;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      interface_select <= i[1];
      byte_lane_select <= i[0];
      im = !i[1] ? 2'h0 : (i[0] ? 2'h1 : 2'h2);
      #5;
      chk_word(iface_mode, im);
      bus(1'b0, adcmd_pkg::OFS_STATUS, 32'h0000_0000);
      chk_word(d[5:4], im);
    end
    $display("t_iface done");
  endtask
  // Step size in picovolts, read-only places
  task t_code;
    bus(1'b0, adcmd_pkg::OFS_LSB, 32'h0000_0000);
    chk_word(d, 32'h048C_2B58);
    range_select <= 1'b0;
    bus(1'b1, adcmd_pkg::OFS_CODE, 32'hFFFF_FFFF);
    bus(1'b0, adcmd_pkg::OFS_CODE, 32'h0000_0000);
    chk_word(d, 32'h0000_0012);
    bus(1'b0, adcmd_pkg::OFS_LSB, 32'h0000_0000);
    chk_word(d, 32'h0246_15AC);
    bus(1'b0, 4'h1, 32'h0000_0000);
    chk_word(d, 32'h0000_0000);
    $display("t_code done");
  endtask
  task t_settle;
    busy_len;
    range_select <= 1'b1;
    busy_len;
    chk_word(n, 32'h0000_07D0);
    power_down_n <= 1'b0;
    @(posedge clk_sys);
    power_down_n <= 1'b1;
    busy_len;
    chk_word(n, 32'h0000_0004);
    bus(1'b1, adcmd_pkg::OFS_CTRL, 32'h0000_0000);
    range_select <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk_word(settle_busy, 1'b0);
    bus(1'b0, adcmd_pkg::OFS_CTRL, 32'h0000_0000);
    chk_word(d, 32'h0000_0000);
    $display("t_settle done");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    {rst_n, range_select, interface_select, byte_lane_select, ext_level} = '0;
    {reference_select, power_down_n, avs_read, avs_write} = 4'b1100;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    chk_word(bandgap_en, 1'b1);
    rst_n <= 1'b1;
    bus(1'b0, adcmd_pkg::OFS_CTRL, 32'h0000_0000);
    chk_word(d, 32'h0000_0001);
    t_ref;
    t_pwr;
    t_iface;
    t_code;
    t_settle;
    tally_and_finish;
  end
endmodule
